//--- verilog/faepc_pkg.sv
package faepc_pkg;

   // Command opcodes
   localparam logic [7:0] OP_RD_PROT      = 8'h2b;
   localparam logic [7:0] OP_PG_PROT      = 8'h2f;
   localparam logic [7:0] OP_RD_BANK_A    = 8'h16;
   localparam logic [7:0] OP_RD_BANK_B    = 8'hc8;
   localparam logic [7:0] OP_WR_BANK_VA   = 8'h17;
   localparam logic [7:0] OP_WR_BANK_VB   = 8'hc5;
   localparam logic [7:0] OP_WR_BANK_NV   = 8'h18;
   localparam logic [7:0] OP_ENTER_WIDE   = 8'hb7;
   localparam logic [7:0] OP_EXIT_WIDE    = 8'h29;
   localparam logic [7:0] OP_CLEAR_ERR    = 8'h82;

   // Bank and address width register
   localparam int          BANK_WIDTH_BIT = 7;
   localparam int          BANK_BITS      = 2;
   localparam logic [7:0]  BANK_RESET     = 8'h00;
   localparam logic [7:0]  BANK_WR_MASK   = 8'h83;

   // Protection configuration register
   localparam int          PROT_PST_BIT   = 1;
   localparam int          PROT_PWD_BIT   = 2;
   localparam int          PROT_PLACE_BIT = 15;
   localparam logic [15:0] PROT_RESET     = 16'hffff;

   // Array geometry
   localparam int          ARRAY_ADDR_W   = 26;
   localparam int          LOW_ADDR_W     = 24;
   localparam int          PARAM_REGION_LOG2 = 17;

   // Program time of the configuration word, typical page program
   localparam int          CLK_PERIOD_PS  = 5000;
   localparam int          PROG_TIME_NS   = 200000;
   localparam int          PROG_CYCLES    = (PROG_TIME_NS * 1000) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      FAEPC_IDLE,
      FAEPC_PROG_PROT,
      FAEPC_PROG_BANK
   } faepc_state_t;

endpackage

//--- verilog/faepc_busy_timer.sv
`timescale 1ns/1ps
`default_nettype none
module faepc_busy_timer #(
   parameter int COUNT = 40000
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   localparam int CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          busy_r;
   logic          busy_nxt;

   always_comb begin
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      done     = 1'b0;
      if (busy_r) begin
         if (cnt_r == LAST) begin
            busy_nxt = 1'b0;
            done     = 1'b1;
            cnt_nxt  = '0;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end else if (start) begin
         busy_nxt = 1'b1;
         cnt_nxt  = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign busy = busy_r;
endmodule
`default_nettype wire

//--- verilog/faepc_regs.sv
// Behaviour
// RL1 - Width bit zero: bank bits extend address
// RL2 - Width bit one: bank ignored, four bytes
// RL3 - Bit7 width, bits1:0 bank, rest zero
// RL4 - Width bit starts cleared
// RL5 - 2Bh reads, 2Fh programs protection word
// RL6 - Bits 2,1 lock password/persistent mode
// RL7 - Decode 11 none, 10 persistent, 01 password
// RL8 - Programming both locks zero aborts, errors
// RL9 - Locked mode bits reject programming, error
// RL10 - Programming busy like page, shown busy
// RL11 - Host programs password before password lock
// RL12 - Bit15 zero top, one bottom, default one
// RL13 - Parameter region replaces two large blocks
// RL14 - Placement bit cannot return to one
// RL15 - Placement programmable after lock unless frozen
// RL16 - Host sets placement before array use
// RL17 - Large-block variant: placement bit reserved
// RL18 - Boot protect end independent of placement
// RL19 - Ships persistent mode, all sectors unprotected
// RL20 - Reserved writes ignored, read defaults
// RL21 - Bank read/write and wide-mode opcodes
// RL22 - Bad lock programming also sets protection error
// RL23 - Error flags sticky until clear or reset
// RL24 - Freeze sticky until hardware reset
`timescale 1ns/1ps
`default_nettype none
module faepc_regs
   import faepc_pkg::*;
#(
   parameter int   PROG_CYCLES_P = faepc_pkg::PROG_CYCLES,
   parameter logic LARGE_BLOCKS  = 1'b0
) (
   input  wire logic                              sys_clk,
   input  wire logic                              sys_rst,
   input  wire logic                              sw_reset,
   input  wire logic                              cmd_valid,
   input  wire logic [7:0]                        cmd_opcode,
   input  wire logic [15:0]                       cmd_wdata,
   output logic [15:0]                            rd_data,
   output logic                                   rd_valid,
   input  wire logic                              addr_valid,
   input  wire logic [7:0]                        addr_high,
   input  wire logic [faepc_pkg::LOW_ADDR_W-1:0]  addr_low,
   output logic [faepc_pkg::ARRAY_ADDR_W-1:0]     array_addr,
   output logic                                   param_region_hit,
   input  wire logic                              freeze_set,
   input  wire logic                              erase_fail,
   output logic                                   wide_address,
   output logic                                   write_in_progress,
   output logic                                   program_error,
   output logic                                   erase_error,
   output logic                                   protection_error_flag,
   output logic                                   password_mode,
   output logic                                   mode_locked,
   output logic                                   freeze
);
   import faepc_pkg::*;

   faepc_state_t                state_r;
   faepc_state_t                state_nxt;
   logic [7:0]                  bank_r;
   logic [7:0]                  bank_nxt;
   logic [7:0]                  nvbank_r;
   logic [7:0]                  nvbank_nxt;
   logic [15:0]                 prot_r;
   logic [15:0]                 prot_nxt;
   logic [15:0]                 pend_r;
   logic [15:0]                 pend_nxt;
   logic                        perr_r;
   logic                        perr_nxt;
   logic                        eerr_r;
   logic                        eerr_nxt;
   logic                        prerr_r;
   logic                        prerr_nxt;
   logic                        freeze_r;
   logic                        freeze_nxt;
   logic [15:0]                 rd_data_r;
   logic [15:0]                 rd_data_nxt;
   logic                        rd_valid_r;
   logic                        rd_valid_nxt;
   logic [ARRAY_ADDR_W-1:0]     addr_r;
   logic [ARRAY_ADDR_W-1:0]     addr_nxt;
   logic                        hit_r;
   logic                        hit_nxt;
   logic                        start;
   logic                        busy;
   logic                        done;
   logic                        locked;
   logic                        bad_lock_req;
   logic                        is_wr;
   logic [15:0]                 prot_view;

   faepc_busy_timer #(
      .COUNT   (PROG_CYCLES_P)
   ) u_timer (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .start   (start),
      .busy    (busy),
      .done    (done)
   );

   // Any zero in the lock pair means a mode has been chosen for good
   assign locked = ~&prot_r[PROT_PWD_BIT:PROT_PST_BIT];  // [RL7]
   // A program that leaves both lock bits at one touches nothing there, so only a zero is an attempt
   assign bad_lock_req = (cmd_wdata[PROT_PWD_BIT:PROT_PST_BIT] == 2'b00) ||
                         (locked && cmd_wdata[PROT_PWD_BIT:PROT_PST_BIT] != 2'b11);  // [RL8] [RL9]
   assign is_wr = (cmd_opcode == OP_PG_PROT) || (cmd_opcode == OP_WR_BANK_VA) ||
                  (cmd_opcode == OP_WR_BANK_VB) || (cmd_opcode == OP_WR_BANK_NV) ||
                  (cmd_opcode == OP_ENTER_WIDE) || (cmd_opcode == OP_EXIT_WIDE);

   // Reserved bits read as their shipped value; placement is reserved on the large-block variant
   always_comb begin
      prot_view = PROT_RESET;  // [RL20]
      prot_view[PROT_PWD_BIT:PROT_PST_BIT] = prot_r[PROT_PWD_BIT:PROT_PST_BIT];
      prot_view[PROT_PLACE_BIT] = LARGE_BLOCKS ? 1'b1 : prot_r[PROT_PLACE_BIT];  // [RL17]
   end

   always_comb begin
      state_nxt    = state_r;
      bank_nxt     = bank_r;
      nvbank_nxt   = nvbank_r;
      prot_nxt     = prot_r;
      pend_nxt     = pend_r;
      perr_nxt     = perr_r;
      eerr_nxt     = eerr_r;
      prerr_nxt    = prerr_r;
      freeze_nxt   = freeze_r;
      rd_data_nxt  = rd_data_r;
      rd_valid_nxt = 1'b0;
      addr_nxt     = addr_r;
      hit_nxt      = hit_r;
      start        = 1'b0;

      if (freeze_set) begin
         freeze_nxt = 1'b1;  // [RL24]
      end
      if (sw_reset) begin
         bank_nxt  = nvbank_r;
         perr_nxt  = 1'b0;  // [RL23]
         eerr_nxt  = 1'b0;
         prerr_nxt = 1'b0;
      end

      // Reads are served even while a program runs; writes that arrive while busy is high are dropped
      if (cmd_valid) begin
         case (cmd_opcode)
            OP_RD_PROT: begin
               rd_data_nxt  = prot_view;  // [RL5]
               rd_valid_nxt = 1'b1;
            end
            OP_RD_BANK_A, OP_RD_BANK_B: begin
               rd_data_nxt  = {8'h00, bank_r};  // [RL21]
               rd_valid_nxt = 1'b1;
            end
            OP_CLEAR_ERR: begin
               perr_nxt  = 1'b0;  // [RL23]
               eerr_nxt  = 1'b0;
               prerr_nxt = 1'b0;
            end
            default: begin
            end
         endcase
         if (!busy && is_wr) begin
            case (cmd_opcode)
               OP_PG_PROT: begin
                  if (bad_lock_req) begin
                     perr_nxt  = 1'b1;  // [RL8] [RL9]
                     prerr_nxt = 1'b1;  // [RL22]
                  end else begin
                     pend_nxt  = cmd_wdata;
                     state_nxt = FAEPC_PROG_PROT;
                     start     = 1'b1;  // [RL10]
                  end
               end
               OP_WR_BANK_VA, OP_WR_BANK_VB: begin
                  bank_nxt = cmd_wdata[7:0] & BANK_WR_MASK;  // [RL3] [RL20] [RL21]
               end
               OP_WR_BANK_NV: begin
                  pend_nxt  = {8'h00, cmd_wdata[7:0] & BANK_WR_MASK};
                  state_nxt = FAEPC_PROG_BANK;
                  start     = 1'b1;
               end
               OP_ENTER_WIDE: begin
                  bank_nxt[BANK_WIDTH_BIT] = 1'b1;  // [RL21]
               end
               OP_EXIT_WIDE: begin
                  bank_nxt[BANK_WIDTH_BIT] = 1'b0;
               end
               default: begin
               end
            endcase
         end
      end

      if (done) begin
         case (state_r)
            FAEPC_PROG_PROT: begin
               // Programming only clears bits, so an OTP one can never come back
               prot_nxt[PROT_PWD_BIT:PROT_PST_BIT] &= pend_r[PROT_PWD_BIT:PROT_PST_BIT];  // [RL6]
               if (!LARGE_BLOCKS && !freeze_r && !pend_r[PROT_PLACE_BIT]) begin
                  prot_nxt[PROT_PLACE_BIT] = 1'b0;  // [RL12] [RL14] [RL15]
               end
            end
            FAEPC_PROG_BANK: begin
               nvbank_nxt = pend_r[7:0];
               bank_nxt   = pend_r[7:0];
            end
            default: begin
            end
         endcase
         state_nxt = FAEPC_IDLE;
      end

      // A failure reported together with a clear still lands
      if (erase_fail) begin
         eerr_nxt = 1'b1;
      end

      if (addr_valid) begin
         if (bank_r[BANK_WIDTH_BIT]) begin
            addr_nxt = {addr_high[BANK_BITS-1:0], addr_low};  // [RL2]
         end else begin
            addr_nxt = {bank_r[BANK_BITS-1:0], addr_low};  // [RL1]
         end
         // Placement alone decides the end; the boot-protect end is never consulted
         if (LARGE_BLOCKS) begin
            hit_nxt = 1'b0;  // [RL17]
         end else if (prot_r[PROT_PLACE_BIT]) begin
            hit_nxt = ~|addr_nxt[ARRAY_ADDR_W-1:PARAM_REGION_LOG2];  // [RL13] [RL18]
         end else begin
            hit_nxt = &addr_nxt[ARRAY_ADDR_W-1:PARAM_REGION_LOG2];  // [RL13]
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r    <= FAEPC_IDLE;
         bank_r     <= BANK_RESET;  // [RL4]
         nvbank_r   <= BANK_RESET;
         prot_r     <= PROT_RESET;  // [RL19]
         pend_r     <= PROT_RESET;
         perr_r     <= 1'b0;
         eerr_r     <= 1'b0;
         prerr_r    <= 1'b0;
         freeze_r   <= 1'b0;
         rd_data_r  <= 16'h0000;
         rd_valid_r <= 1'b0;
         addr_r     <= '0;
         hit_r      <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         bank_r     <= bank_nxt;
         nvbank_r   <= nvbank_nxt;
         prot_r     <= prot_nxt;
         pend_r     <= pend_nxt;
         perr_r     <= perr_nxt;
         eerr_r     <= eerr_nxt;
         prerr_r    <= prerr_nxt;
         freeze_r   <= freeze_nxt;
         rd_data_r  <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
         addr_r     <= addr_nxt;
         hit_r      <= hit_nxt;
      end
   end

   assign rd_data               = rd_data_r;
   assign rd_valid              = rd_valid_r;
   assign array_addr            = addr_r;
   assign param_region_hit      = hit_r;
   assign wide_address          = bank_r[BANK_WIDTH_BIT];
   assign write_in_progress     = busy;
   assign program_error         = perr_r;
   assign erase_error           = eerr_r;
   assign protection_error_flag = prerr_r;
   assign password_mode         = (prot_r[PROT_PWD_BIT:PROT_PST_BIT] == 2'b01);  // [RL7]
   assign mode_locked           = locked;
   assign freeze                = freeze_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_bad_prog;
      cmd_valid && !busy && cmd_opcode == OP_PG_PROT && bad_lock_req;
   endsequence
   sequence s_abort;
      perr_r && prerr_r && !busy;
   endsequence

   property p_bank_ext;
      addr_valid && !bank_r[BANK_WIDTH_BIT] |=> array_addr[ARRAY_ADDR_W-1 -: 2] == $past(bank_r[1:0]);
   endproperty
   a_bank_ext: assert property (p_bank_ext) else $error("bank bits not used in narrow mode"); // [RL1]

   property p_wide_addr;
      addr_valid && bank_r[BANK_WIDTH_BIT] |=> array_addr[ARRAY_ADDR_W-1 -: 2] == $past(addr_high[1:0]);
   endproperty
   a_wide_addr: assert property (p_wide_addr) else $error("wide address not taken from host"); // [RL2]

   property p_bank_reserved;
      bank_r[6:2] == 5'h00;
   endproperty
   a_bank_reserved: assert property (p_bank_reserved) else $error("reserved bank bits set"); // [RL3]

   property p_bad_prog;
      s_bad_prog |=> s_abort ##1 !busy;
   endproperty
   a_bad_prog: assert property (p_bad_prog) else $error("illegal lock program not aborted"); // [RL8]

   property p_lock_stable;
      locked |=> $stable(prot_r[PROT_PWD_BIT:PROT_PST_BIT]);
   endproperty
   a_lock_stable: assert property (p_lock_stable) else $error("locked mode bits changed"); // [RL9]

   property p_commit_after_busy;
      !$stable(prot_r) |-> $past(busy) && !busy;
   endproperty
   a_commit_after_busy: assert property (p_commit_after_busy) else $error("config changed without busy"); // [RL10]

   property p_place_otp;
      !prot_r[PROT_PLACE_BIT] |=> !prot_r[PROT_PLACE_BIT];
   endproperty
   a_place_otp: assert property (p_place_otp) else $error("placement returned to one"); // [RL14]

   property p_large_reserved;
      LARGE_BLOCKS |-> rd_data_r[PROT_PLACE_BIT] || !$past(rd_valid_nxt) || $past(cmd_opcode) != OP_RD_PROT;
   endproperty
   a_large_reserved: assert property (p_large_reserved) else $error("reserved placement read low"); // [RL17]

   property p_err_sticky;
      perr_r && !(cmd_valid && cmd_opcode == OP_CLEAR_ERR) && !sw_reset |=> perr_r;
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("program error dropped"); // [RL23]

   property p_freeze_sticky;
      freeze_r |=> freeze_r;
   endproperty
   a_freeze_sticky: assert property (p_freeze_sticky) else $error("freeze cleared without reset"); // [RL24]
endmodule
`default_nettype wire

//--- tb/faepc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module faepc_host_model (
   input  wire logic        sys_clk,
   output logic             sw_reset,
   output logic             cmd_valid,
   output logic [7:0]       cmd_opcode,
   output logic [15:0]      cmd_wdata,
   input  wire logic [15:0] rd_data,
   input  wire logic        rd_valid,
   output logic             addr_valid,
   output logic [7:0]       addr_high,
   output logic [23:0]      addr_low,
   output logic             freeze_set,
   output logic             erase_fail,
   input  wire logic        write_in_progress
);
   // Only the strobes start idle; data lines stay unknown until a strobe qualifies them
   initial begin
      {sw_reset, freeze_set, erase_fail, cmd_valid, addr_valid} = 5'h00;
   end
   // One command per call; released lines carry inverted data, not the last value
   // Password lock is requested right after a hardware reset; no password is ever set
   // The first test sequence uses the array at the default placement before placement is programmed
   task automatic cmd(input logic [7:0] op, input logic [15:0] wd);
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_opcode = op;
      cmd_wdata = wd;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      cmd_opcode = ~op;
      cmd_wdata = ~wd;
   endtask
   task automatic rd(input logic [7:0] op, output logic [15:0] d, output logic v);
      cmd(op, 16'h0000);
      d = rd_data;
      v = rd_valid;
   endtask
   // Poll busy as the host would, with a bound so a stuck flag cannot hang
   task automatic wait_idle(output int n);
      n = 0;
      while (write_in_progress === 1'b1 && n < 50) begin
         n++;
         @(negedge sys_clk);
      end
   endtask
   // Wide mode: host supplies the fourth byte itself
   task automatic addr(input logic [7:0] h, input logic [23:0] l);
      @(negedge sys_clk);
      addr_valid = 1'b1;
      addr_high = h;
      addr_low = l;
      @(negedge sys_clk);
      addr_valid = 1'b0;
      addr_high = ~h;
      addr_low = ~l;
   endtask
   task automatic pulse(input logic [2:0] m);
      @(negedge sys_clk);
      {sw_reset, freeze_set, erase_fail} = m;
      @(negedge sys_clk);
      {sw_reset, freeze_set, erase_fail} = 3'h0;
   endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
   $display("mismatch t=%0t got %h exp %h", $time, got, exp); end end
module tb_top;
   import faepc_pkg::*;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        sw_reset, cmd_valid, addr_valid, freeze_set, erase_fail, rd_valid;
   logic [7:0]  cmd_opcode, addr_high;
   logic [15:0] cmd_wdata, rd_data, d;
   logic [23:0] addr_low;
   logic [25:0] array_addr;
   logic        param_region_hit, wide_address, write_in_progress, program_error;
   logic        erase_error, protection_error_flag, password_mode, mode_locked, freeze, v;
   int          miscompares = 0;
   int          compares = 0;
   int          n;
   logic [15:0] rd_data_lg;
   logic        hit_lg;
   always #2.5 sys_clk = ~sys_clk;
   faepc_host_model u_faepc_host_model (.sys_clk(sys_clk), .sw_reset(sw_reset), .cmd_valid(cmd_valid),
      .cmd_opcode(cmd_opcode), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
      .addr_valid(addr_valid), .addr_high(addr_high), .addr_low(addr_low), .freeze_set(freeze_set),
      .erase_fail(erase_fail), .write_in_progress(write_in_progress));
   // Short program time keeps the run brief; busy length is checked against it
   faepc_regs #(.PROG_CYCLES_P(8), .LARGE_BLOCKS(1'b0)) u_faepc_regs (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .sw_reset(sw_reset), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
      .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .addr_valid(addr_valid),
      .addr_high(addr_high), .addr_low(addr_low), .array_addr(array_addr),
      .param_region_hit(param_region_hit), .freeze_set(freeze_set), .erase_fail(erase_fail),
      .wide_address(wide_address), .write_in_progress(write_in_progress), .program_error(program_error),
      .erase_error(erase_error), .protection_error_flag(protection_error_flag),
      .password_mode(password_mode), .mode_locked(mode_locked), .freeze(freeze));
   // Large-block variant shares the stimulus; only its protection read and region hit are compared
   faepc_regs #(.PROG_CYCLES_P(8), .LARGE_BLOCKS(1'b1)) u_faepc_regs_large (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .sw_reset(sw_reset), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
      .cmd_wdata(cmd_wdata), .rd_data(rd_data_lg), .rd_valid(), .addr_valid(addr_valid),
      .addr_high(addr_high), .addr_low(addr_low), .array_addr(),
      .param_region_hit(hit_lg), .freeze_set(freeze_set), .erase_fail(erase_fail),
      .wide_address(), .write_in_progress(), .program_error(),
      .erase_error(), .protection_error_flag(),
      .password_mode(), .mode_locked(), .freeze());
   task automatic close_out;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic hw_reset;
      @(negedge sys_clk);
      sys_rst = 1'b1;
      repeat (6) @(negedge sys_clk);
      sys_rst = 1'b0;
   endtask
   initial begin
      #(5 * 5000);
      miscompares++;
      close_out();
   end
   initial begin
      repeat (6) @(negedge sys_clk);
      sys_rst = 1'b0;
      u_faepc_host_model.rd(OP_RD_BANK_A, d, v);
      `CHK(d, 16'h0000)
      `CHK(v, 1'b1)
      u_faepc_host_model.rd(OP_RD_PROT, d, v);
      `CHK(d, 16'hffff)
      `CHK({mode_locked, password_mode}, 2'b00)
      u_faepc_host_model.cmd(OP_WR_BANK_VA, 16'h00ff);
      u_faepc_host_model.rd(OP_RD_BANK_B, d, v);
      `CHK(d, 16'h0083)
      `CHK(wide_address, 1'b1)
      u_faepc_host_model.cmd(OP_WR_BANK_VB, 16'h0002);
      `CHK(wide_address, 1'b0)
      u_faepc_host_model.addr(8'h03, 24'h123456);
      `CHK(array_addr, 26'h2123456)
      u_faepc_host_model.cmd(OP_ENTER_WIDE, 16'h0000);
      `CHK(wide_address, 1'b1)
      u_faepc_host_model.addr(8'h01, 24'h0abcde);
      `CHK(array_addr, 26'h10abcde)
      u_faepc_host_model.cmd(OP_EXIT_WIDE, 16'h0000);
      `CHK(wide_address, 1'b0)
      u_faepc_host_model.cmd(OP_WR_BANK_VA, 16'h0000);
      u_faepc_host_model.addr(8'h00, 24'h01ffff);
      `CHK(param_region_hit, 1'b1)
      u_faepc_host_model.addr(8'h00, 24'h020000);
      `CHK(param_region_hit, 1'b0)
      u_faepc_host_model.cmd(OP_PG_PROT, 16'hfff9);
      `CHK({program_error, protection_error_flag, write_in_progress}, 3'b110)
      u_faepc_host_model.rd(OP_RD_PROT, d, v);
      `CHK(d, 16'hffff)
      `CHK(program_error, 1'b1)
      u_faepc_host_model.cmd(OP_CLEAR_ERR, 16'h0000);
      `CHK({program_error, protection_error_flag}, 2'b00)
      u_faepc_host_model.cmd(OP_PG_PROT, 16'h7ffd);
      u_faepc_host_model.wait_idle(n);
      `CHK(n, 8)
      u_faepc_host_model.rd(OP_RD_PROT, d, v);
      `CHK(d, 16'h7ffd)
      `CHK(rd_data_lg, 16'hfffd)
      `CHK({mode_locked, password_mode}, 2'b10)
      u_faepc_host_model.cmd(OP_WR_BANK_VA, 16'h0003);
      u_faepc_host_model.addr(8'h00, 24'hfe0000);
      `CHK(param_region_hit, 1'b1)
      `CHK(hit_lg, 1'b0)
      u_faepc_host_model.cmd(OP_PG_PROT, 16'hfffb);
      `CHK({program_error, protection_error_flag}, 2'b11)
      u_faepc_host_model.rd(OP_RD_PROT, d, v);
      `CHK(d, 16'h7ffd)
      u_faepc_host_model.cmd(OP_CLEAR_ERR, 16'h0000);
      u_faepc_host_model.cmd(OP_PG_PROT, 16'hffff);
      u_faepc_host_model.wait_idle(n);
      u_faepc_host_model.rd(OP_RD_PROT, d, v);
      `CHK(d, 16'h7ffd)
      `CHK(program_error, 1'b0)
      u_faepc_host_model.pulse(3'b001);
      `CHK(erase_error, 1'b1)
      u_faepc_host_model.pulse(3'b100);
      `CHK(erase_error, 1'b0)
      u_faepc_host_model.cmd(OP_WR_BANK_NV, 16'h0001);
      u_faepc_host_model.cmd(OP_WR_BANK_VA, 16'h0083);
      u_faepc_host_model.rd(OP_RD_BANK_A, d, v);
      `CHK(d, 16'h0000)
      `CHK(wide_address, 1'b0)
      u_faepc_host_model.wait_idle(n);
      u_faepc_host_model.cmd(OP_WR_BANK_VA, 16'h0000);
      u_faepc_host_model.pulse(3'b100);
      u_faepc_host_model.rd(OP_RD_BANK_A, d, v);
      `CHK(d, 16'h0001)
      u_faepc_host_model.pulse(3'b010);
      u_faepc_host_model.pulse(3'b100);
      `CHK(freeze, 1'b1)
      hw_reset();
      `CHK(freeze, 1'b0)
      u_faepc_host_model.cmd(OP_PG_PROT, 16'hfffb);
      u_faepc_host_model.wait_idle(n);
      `CHK({mode_locked, password_mode}, 2'b11)
      u_faepc_host_model.cmd(OP_PG_PROT, 16'h7fff);
      u_faepc_host_model.wait_idle(n);
      u_faepc_host_model.rd(OP_RD_PROT, d, v);
      `CHK(d, 16'h7ffb)
      `CHK(program_error, 1'b0)
      hw_reset();
      u_faepc_host_model.pulse(3'b010);
      u_faepc_host_model.cmd(OP_PG_PROT, 16'h7fff);
      u_faepc_host_model.wait_idle(n);
      u_faepc_host_model.rd(OP_RD_PROT, d, v);
      `CHK(d, 16'hffff)
      close_out();
   end
endmodule
`default_nettype wire
